// ---- bsc_boundary_scan.sv ----
`timescale 1ns/1ps
//==============================================================================
// Boundary scan data registers and cells
module bsc_boundary_scan
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   tck,
   input  wire logic                   trst_n,
   input  wire logic                   tdi,
   input  wire bsc_pkg::bsc_tap_s      tap,
   input  wire logic [bsc_pkg::ID_W-1:0] id_value,
   output logic                        tdo,
   output logic                        tdo_oe,
   input  wire bsc_pkg::bsc_pad_in_s   pad_in,
   output bsc_pkg::bsc_pad_out_s       pad_out,
   input  wire bsc_pkg::bsc_core_out_s core_out,
   output bsc_pkg::bsc_core_in_s       core_in
);
   import bsc_pkg::*;

   //===========================================================================
   // Signals
   bsc_tck_s           t_ff;
   bsc_tck_s           nxt_t;
   bsc_sys_s           s_ff;
   bsc_sys_s           nxt_s;
   logic [UPD_W-1:0]   latch_q;
   logic [N_BIDIR-1:0] eff_oe;
   logic [N_BIDIR-1:0] cap_dat;
   logic               dr_out;
   logic [1:0]         tdo_d;
   logic [1:0]         tdo_q;

   //===========================================================================
   // Two-way capture mux, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < N_BIDIR; gi++)
      begin : g_bidir
         assign eff_oe[gi]  = t_ff.extest ? latch_q[LAT_OE + gi] : t_ff.core_s.oe[gi];
         assign cap_dat[gi] = (!t_ff.extest && eff_oe[gi]) ? t_ff.core_s.do_[gi] // R8
                                                          : t_ff.pad_s.di[gi];  // R9
      end
   endgenerate

   //===========================================================================
   // Test clock domain
   always_comb
   begin
      nxt_t        = t_ff;
      nxt_t.pad_m  = pad_in;
      nxt_t.pad_s  = t_ff.pad_m;
      nxt_t.core_m = core_out;
      nxt_t.core_s = t_ff.core_m;
      nxt_t.extest = (tap.instr == INS_EXTEST);
      nxt_t.drive  = (tap.instr == INS_EXTEST) || (tap.instr == INS_CLAMP); // R3
      nxt_t.highz  = (tap.instr == INS_HIGHZ);
      case (tap.instr)
         INS_EXTEST,
         INS_SAMPLE: nxt_t.sel = DR_BSR; // R2
         INS_IDCODE: nxt_t.sel = DR_ID;
         default:    nxt_t.sel = DR_BYPASS;
      endcase
      if (tap.capture_dr)
      begin
         case (t_ff.sel)
            DR_BSR:
            begin
               nxt_t.chain[OFS_OBS +: N_OBS]   = t_ff.pad_s.obs;   // R6
               nxt_t.chain[OFS_TX +: N_TX]     = t_ff.core_s.tx_do;
               nxt_t.chain[OFS_OE +: N_BIDIR]  = eff_oe;           // R7
               nxt_t.chain[OFS_DAT +: N_BIDIR] = cap_dat;          // R7
            end
            DR_ID:   nxt_t.id = id_value;
            default: nxt_t.bypass = BYPASS_CAPTURE; // R13
         endcase
      end
      else if (tap.shift_dr)
      begin
         case (t_ff.sel) // R1 R11
            DR_BSR:  nxt_t.chain = {tdi, t_ff.chain[CHAIN_LEN-1:1]};
            DR_ID:   nxt_t.id = {tdi, t_ff.id[ID_W-1:1]};
            default: nxt_t.bypass = tdi;
         endcase
      end
   end

   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         t_ff <= '0; // R15
      end
      else
      begin
         t_ff <= nxt_t;
      end
   end

   //===========================================================================
   // Falling edge update latches
   bsc_neg_stage #(.WIDTH(UPD_W)) u_latch
   (
      .clk   (tck),
      .rst_n (trst_n),
      .en    (tap.update_dr && (t_ff.sel == DR_BSR)), // R5
      .d     (t_ff.chain[OFS_TX +: UPD_W]),
      .q     (latch_q)
   );

   //===========================================================================
   // Serial output select, changed on falling edge
   always_comb
   begin
      case (t_ff.sel) // R1
         DR_BSR:  dr_out = t_ff.chain[0];
         DR_ID:   dr_out = t_ff.id[0];
         default: dr_out = t_ff.bypass;
      endcase
      tdo_d[1] = tap.shift_dr || tap.shift_ir;               // R12
      tdo_d[0] = tap.shift_ir ? tap.ir_serial : dr_out;
   end

   bsc_neg_stage #(.WIDTH(2)) u_tdo
   (
      .clk   (tck),
      .rst_n (trst_n),
      .en    (1'b1),
      .d     (tdo_d),
      .q     (tdo_q)
   );

   assign tdo_oe = tdo_q[1]; // R12
   assign tdo    = tdo_q[0]; // R11

   //===========================================================================
   // System clock domain: pin drive and core pass-through
   always_comb
   begin
      nxt_s         = s_ff;
      nxt_s.latch_m = latch_q;
      nxt_s.latch_s = s_ff.latch_m;
      nxt_s.drive_m = t_ff.drive;
      nxt_s.drive_s = s_ff.drive_m;
      nxt_s.highz_m = t_ff.highz;
      nxt_s.highz_s = s_ff.highz_m;
      nxt_s.pad_m   = pad_in;
      nxt_s.pad_s   = s_ff.pad_m;
      nxt_s.core_in = s_ff.pad_s; // R6 R14
      if (s_ff.highz_s)
      begin
         nxt_s.pad_out.tx_do = core_out.tx_do;
         nxt_s.pad_out.tx_oe = '0;
         nxt_s.pad_out.do_   = core_out.do_;
         nxt_s.pad_out.oe    = '0;
      end
      else if (s_ff.drive_s)
      begin
         nxt_s.pad_out.tx_do = s_ff.latch_s[LAT_TX +: N_TX];     // R3 R10
         nxt_s.pad_out.tx_oe = '1;
         nxt_s.pad_out.do_   = s_ff.latch_s[LAT_DAT +: N_BIDIR]; // R3
         nxt_s.pad_out.oe    = s_ff.latch_s[LAT_OE +: N_BIDIR];  // R3
      end
      else
      begin
         nxt_s.pad_out.tx_do = core_out.tx_do; // R14
         nxt_s.pad_out.tx_oe = '1;
         nxt_s.pad_out.do_   = core_out.do_;
         nxt_s.pad_out.oe    = core_out.oe;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign pad_out = s_ff.pad_out;
   assign core_in = s_ff.core_in;

endmodule

// ---- bsc_neg_stage.sv ----
`timescale 1ns/1ps
//==============================================================================
// Falling edge register stage
module bsc_neg_stage
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             en,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("bsc_neg_stage: WIDTH must be at least 1");
      end
   end

   logic [WIDTH-1:0] nxt_q;

   always_comb
   begin
      nxt_q = en ? d : q;
   end

   always_ff @(negedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= nxt_q;
      end
   end

endmodule

// ---- bsc_pkg.sv ----
//==============================================================================
// What this block does
// R1: Bypass, boundary and identification registers share one serial input and output.
// R2: Boundary chain sits between serial input and output for external test or sample.
// R3: External test drives the held output latches onto pins and enables at once.
// R4: Tester preloads the boundary cells with sample/preload before external test.
// R5: Every transmit, enable and data cell updates through a falling test-clock edge latch; observe cells have none.
// R6: Input cells only observe their pin; they never drive pin or core.
// R7: A two-way pin has one enable cell and one capture cell with a mux.
// R8: Outside external test with the enable high, capture core-to-pad data.
// R9: With the enable low or under external test, capture pad-to-core data.
// R10: Receive lanes and straps observe, transmit pairs control, bus and gpio both.
// R11: Serial input and mode sampled on rising edge; serial output changes on falling.
// R12: Serial output is driven only while shifting data or instruction.
// R13: Bypass bit loads zero in capture with bypass selected.
// R14: Outside external test, clamp and high-impedance, the cells pass core and pad signals unchanged.
// R15: Test reset returns test logic to reset, leaving every cell transparent.
//==============================================================================
package bsc_pkg;

   //===========================================================================
   // Cell counts
   localparam int N_OBS     = 30;
   localparam int N_TX      = 8;
   localparam int N_BIDIR   = 15;
   localparam int UPD_W     = N_TX + 2 * N_BIDIR;
   localparam int CHAIN_LEN = N_OBS + UPD_W;
   localparam int IR_W      = 6;
   localparam int ID_W      = 32;

   //===========================================================================
   // Chain positions, bit 0 nearest the serial output
   localparam int OFS_OBS = 0;
   localparam int OFS_TX  = N_OBS;
   localparam int OFS_OE  = N_OBS + N_TX;
   localparam int OFS_DAT = N_OBS + N_TX + N_BIDIR;

   //===========================================================================
   // Update latch positions
   localparam int LAT_TX  = 0;
   localparam int LAT_OE  = N_TX;
   localparam int LAT_DAT = N_TX + N_BIDIR;

   //===========================================================================
   // Instruction codes
   localparam logic [IR_W-1:0] INS_EXTEST = 6'h00;
   localparam logic [IR_W-1:0] INS_SAMPLE = 6'h01;
   localparam logic [IR_W-1:0] INS_IDCODE = 6'h02;
   localparam logic [IR_W-1:0] INS_HIGHZ  = 6'h03;
   localparam logic [IR_W-1:0] INS_CLAMP  = 6'h3e;
   localparam logic [IR_W-1:0] INS_BYPASS = 6'h3f;

   //===========================================================================
   // Reset and capture values
   localparam logic             BYPASS_CAPTURE = 1'h0;
   localparam logic [UPD_W-1:0] LATCH_RESET    = '0;

   typedef enum logic [1:0]
   {
      DR_BYPASS = 2'b00,
      DR_BSR    = 2'b01,
      DR_ID     = 2'b10
   } bsc_dr_sel_e;

   //===========================================================================
   // Carriers
   typedef struct packed
   {
      logic              capture_dr;
      logic              shift_dr;
      logic              update_dr;
      logic              shift_ir;
      logic              ir_serial;
      logic [IR_W-1:0]   instr;
   } bsc_tap_s;

   typedef struct packed
   {
      logic [N_OBS-1:0]   obs;
      logic [N_BIDIR-1:0] di;
   } bsc_pad_in_s;

   typedef struct packed
   {
      logic [N_TX-1:0]    tx_do;
      logic [N_TX-1:0]    tx_oe;
      logic [N_BIDIR-1:0] do_;
      logic [N_BIDIR-1:0] oe;
   } bsc_pad_out_s;

   typedef struct packed
   {
      logic [N_TX-1:0]    tx_do;
      logic [N_BIDIR-1:0] do_;
      logic [N_BIDIR-1:0] oe;
   } bsc_core_out_s;

   typedef bsc_pad_in_s bsc_core_in_s;

   //===========================================================================
   // Module state
   typedef struct packed
   {
      logic [CHAIN_LEN-1:0] chain;
      logic                 bypass;
      logic [ID_W-1:0]      id;
      logic                 extest;
      logic                 drive;
      logic                 highz;
      bsc_dr_sel_e          sel;
      bsc_pad_in_s          pad_m;
      bsc_pad_in_s          pad_s;
      bsc_core_out_s        core_m;
      bsc_core_out_s        core_s;
   } bsc_tck_s;

   typedef struct packed
   {
      logic [UPD_W-1:0] latch_m;
      logic [UPD_W-1:0] latch_s;
      logic             drive_m;
      logic             drive_s;
      logic             highz_m;
      logic             highz_s;
      bsc_pad_in_s      pad_m;
      bsc_pad_in_s      pad_s;
      bsc_pad_out_s     pad_out;
      bsc_core_in_s     core_in;
   } bsc_sys_s;

endpackage

// ---- bsc_properties.sv ----
`timescale 1ns/1ps
//==========
// Port checker
module bsc_properties
(
   input wire logic                     sys_clk,
   input wire logic                     rst,
   input wire logic                     tck,
   input wire logic                     trst_n,
   input wire logic                     tdi,
   input wire bsc_pkg::bsc_tap_s        tap,
   input wire logic [bsc_pkg::ID_W-1:0] id_value,
   input wire logic                     tdo,
   input wire logic                     tdo_oe,
   input wire bsc_pkg::bsc_pad_in_s     pad_in,
   input wire bsc_pkg::bsc_pad_out_s    pad_out,
   input wire bsc_pkg::bsc_core_out_s   core_out,
   input wire bsc_pkg::bsc_core_in_s    core_in
);
   import bsc_pkg::*;
   logic [2:0] up_ff;
   logic [2:0] nxt_up;
   assign nxt_up = rst ? 3'h0 : up_ff + {2'h0, up_ff != 3'h7};
   always_ff @(posedge sys_clk)
      up_ff <= nxt_up;
   property p_oe;
      @(posedge tck) disable iff (!trst_n) tdo_oe == (tap.shift_dr | tap.shift_ir);
   endproperty
   a_oe: assert property (p_oe) else $error("tdo_oe");
   property p_byp;
      @(posedge tck) disable iff (!trst_n)
      tap.capture_dr && tap.instr == INS_BYPASS ##1 tap.shift_dr |-> !tdo;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass load");
   property p_bsh;
      @(posedge tck) disable iff (!trst_n)
      tap.instr == INS_BYPASS && tap.shift_dr ##1 tap.shift_dr |-> tdo == $past(tdi);
   endproperty
   a_bsh: assert property (p_bsh) else $error("bypass shift");
   property p_id;
      @(posedge tck) disable iff (!trst_n)
      tap.capture_dr && tap.instr == INS_IDCODE ##1 tap.shift_dr |-> tdo == id_value[0];
   endproperty
   a_id: assert property (p_id) else $error("ident bit");
   property p_edge;
      @(posedge sys_clk) disable iff (!trst_n) tck && $past(tck) |-> $stable(tdo);
   endproperty
   a_edge: assert property (p_edge) else $error("tdo edge");
   property p_trst;
      @(posedge sys_clk) disable iff (rst) !trst_n |-> !tdo_oe && !tdo;
   endproperty
   a_trst: assert property (p_trst) else $error("test reset");
   property p_pass;
      @(posedge sys_clk) disable iff (rst)
      up_ff > 3'h3 && tap.instr == INS_BYPASS && $past(tap.instr, 60) == INS_BYPASS
      |-> pad_out.do_ == $past(core_out.do_) && pad_out.oe == $past(core_out.oe);
   endproperty
   a_pass: assert property (p_pass) else $error("pass");
   property p_obs;
      @(posedge sys_clk) disable iff (rst) up_ff > 3'h3 |-> core_in == $past(pad_in, 3);
   endproperty
   a_obs: assert property (p_obs) else $error("core input");
   c_byp: cover property (@(posedge tck) tap.shift_dr && tap.instr == INS_BYPASS);
   c_ext: cover property (@(posedge tck) tap.update_dr && tap.instr == INS_EXTEST);
   c_smp: cover property (@(posedge tck) tap.capture_dr && tap.instr == INS_SAMPLE);
endmodule
bind bsc_boundary_scan bsc_properties u_props (.sys_clk, .rst, .tck, .trst_n, .tdi, .tap,
   .id_value, .tdo, .tdo_oe, .pad_in, .pad_out, .core_out, .core_in);

// ---- bsc_tester.sv ----
`timescale 1ns/1ps
//==========
// Board tester; test clock rests high between frames
// State levels change just after a rising edge, so each falling edge sees the current state
module bsc_tester
(
   output logic              tck,
   output logic              tdi,
   output bsc_pkg::bsc_tap_s tap,
   input  wire logic         tdo
);
   import bsc_pkg::*;
   logic so;
   initial
   begin
      tck = 1'b1;
      tdi = 1'b0;
      tap = {5'h0, INS_BYPASS};
   end
   task automatic step(input logic [2:0] st, input logic d);
      #1;
      {tap.capture_dr, tap.shift_dr, tap.update_dr} = st;
      tdi = st[1] ? d : ~tdi;
      #61.5 tck = 1'b0;
      #62.5 tck = 1'b1;
      so = tdo;
   endtask
   task automatic go(input logic [IR_W-1:0] ins);
      #1.3 tap.instr = ins;
      step(3'h0, 1'b0);
      step(3'h0, 1'b0);
   endtask
   task automatic scan(input logic [IR_W-1:0] ins, input logic [CHAIN_LEN-1:0] din,
                       input int n, output logic [CHAIN_LEN-1:0] dout);
      dout = '0;
      go(ins);
      step(3'h4, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         step(3'h2, din[i]);
         dout[i] = so;
      end
      step(3'h1, 1'b0);
      step(3'h0, 1'b0);
   endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
//==========
// Self-checking bench
module testbench;
   import bsc_pkg::*;
   typedef struct {string nm; logic [CHAIN_LEN-1:0] v;} bsc_note_s;
   localparam logic [ID_W-1:0] ID_VAL = 32'h5a3c1e87; // Arbitrary value
   logic                 sys_clk, rst, trst_n, tck, tdi, tdo, tdo_oe, run;
   logic [31:0]          seed;
   logic [CHAIN_LEN-1:0] din, dout, pre;
   logic [IR_W-1:0]      codes [4] = '{INS_CLAMP, INS_HIGHZ, 6'h10, INS_BYPASS};
   int                   fail_count, n_compared;
   bsc_note_s            exp_q[$], obs_q[$];
   bsc_tap_s             tap;
   bsc_pad_in_s          pad_in;
   bsc_pad_out_s         pad_out;
   bsc_core_out_s        core_out;
   bsc_core_in_s         core_in;
   bsc_boundary_scan dut (.sys_clk, .rst, .tck, .trst_n, .tdi, .tap, .id_value(ID_VAL), .tdo,
                          .tdo_oe, .pad_in, .pad_out, .core_out, .core_in);
   bsc_tester tester (.tck, .tdi, .tap, .tdo);
   initial
   begin
      sys_clk = 1'b0;
      forever
         #2.5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [CHAIN_LEN-1:0] cap(input logic ext, input logic [CHAIN_LEN-1:0] l);
      logic [N_BIDIR-1:0] oe;
      oe = ext ? l[OFS_DAT-1:OFS_OE] : core_out.oe;
      return {ext ? pad_in.di : (oe & core_out.do_) | (~oe & pad_in.di), oe, core_out.tx_do,
              pad_in.obs};
   endfunction
   always @(negedge sys_clk)
      if (run)
      begin
         seed = lfsr(seed);
         core_out = {seed[5:0], seed};
         pad_in = {seed[12:0], seed};
      end
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input bsc_note_s e, input bsc_note_s s);
      n_compared++;
      if (e.v !== s.v)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", e.nm, e.v, s.v);
      end
   endtask
   initial
      forever
      begin
         wait (obs_q.size() > 0);
         chk(exp_q.pop_front(), obs_q.pop_front());
      end
   task automatic scan_chk(input string nm, input logic [IR_W-1:0] ins, input int n,
                           input logic [CHAIN_LEN-1:0] e);
      exp_q.push_back('{nm, e});
      tester.scan(ins, din, n, dout);
      obs_q.push_back('{nm, dout});
   endtask
   task automatic pads(input string nm, input logic [29:0] e);
      int k;
      exp_q.push_back('{nm, {38'h0, e}});
      for (k = 0; k < 99 && {pad_out.do_, pad_out.oe} !== e; k++)
         @(negedge sys_clk);
      if (k == 99)
      begin
         fail_count++;
         end_sim();
      end
      else
         obs_q.push_back('{nm, {38'h0, pad_out.do_, pad_out.oe}});
   endtask
   initial
   begin
      rst = 1'b1;
      trst_n = 1'b0;
      run = 1'b1;
      seed = 32'h9acb9ca7;
      core_out = '0;
      pad_in = '0;
      fail_count = 0;
      n_compared = 0;
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      trst_n = 1'b1;
      foreach (codes[i])
      begin
         din = {seed, seed, seed[3:0]};
         scan_chk("bypass", codes[i], 4, {64'h0, din[2:0], 1'b0});
      end
      scan_chk("ident", INS_IDCODE, ID_W, {36'h0, ID_VAL});
      run = 1'b0;
      pre = {seed[3:0], seed, ~seed};
      din = pre;
      scan_chk("sample", INS_SAMPLE, CHAIN_LEN, cap(1'b0, '0));
      tester.go(INS_EXTEST);
      pads("extest", {pre[67:53], pre[52:38]});
      din = {~seed[3:0], seed, seed};
      scan_chk("capture", INS_EXTEST, CHAIN_LEN, cap(1'b1, pre));
      pads("update", {din[67:53], din[52:38]});
      trst_n = 1'b0;
      tester.go(INS_BYPASS);
      trst_n = 1'b1;
      pads("release", {core_out.do_, core_out.oe});
      run = 1'b1;
      repeat (200) @(negedge sys_clk);
      end_sim();
   end
endmodule
